// *** inc/csp_pkg.sv ***
// Purpose: Shared constants and types for the configurable serial port.
// Assumes: One 10 MHz system clock; 8-bit register port.
// Notes: Bit times are derived from the clock rate and the selected bit rate.
package csp_pkg;
  localparam int CLK_HZ_DEF = 10_000_000;
  localparam int RATES [8] = '{110, 300, 600, 1200, 2400, 4800, 9600, 19200};
  localparam logic [2:0] SEL_110 = 3'h0;
  localparam logic [2:0] SEL_9600 = 3'h6;
  localparam logic [17:0] RATE_MAX = 18'h04b00;
  localparam int BUF_DEPTH = 32;
  localparam int IRQ_W = 5;

  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_STAT = 4'h1;
  localparam logic [3:0] A_HANDLE = 4'h2;
  localparam logic [3:0] A_CFGCH = 4'h3;
  localparam logic [3:0] A_ERR = 4'h4;
  localparam logic [3:0] A_TXD = 4'h5;
  localparam logic [3:0] A_RXD = 4'h6;
  localparam logic [3:0] A_ISTAT = 4'h7;
  localparam logic [3:0] A_IMASK = 4'h8;
  localparam logic [3:0] A_CFG = 4'h9;
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;

  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_RATE = 8'h01;
  localparam logic [7:0] ERR_PAR = 8'h02;
  localparam logic [7:0] ERR_DATA = 8'h03;
  localparam logic [7:0] ERR_STOP = 8'h04;
  localparam logic [7:0] ERR_SYNC = 8'h05;
  localparam logic [7:0] ERR_FAST = 8'h06;
  localparam logic [7:0] ERR_HANDLE = 8'h07;
  localparam logic [7:0] ERR_LONG = 8'h08;

  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_2 = 8'h32;
  localparam logic [7:0] CH_7 = 8'h37;
  localparam logic [7:0] CH_8 = 8'h38;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_N = 8'h4e;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;

  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10} csp_par_t;
  typedef enum logic [2:0] {
    SYNC_NONE = 3'b000, SYNC_SEND = 3'b001, SYNC_RECV = 3'b010, SYNC_BOTH = 3'b011, SYNC_HW = 3'b100
  } csp_sync_t;
  typedef enum logic [1:0] {PS_IDLE = 2'b00, PS_SCAN = 2'b01, PS_FIN = 2'b10} csp_pstate_t;

  typedef struct packed {
    logic [2:0] rate_sel;
    csp_par_t parity;
    logic data8;
    logic stop2;
    csp_sync_t sync;
    logic txdis;
    logic term_en;
    logic [7:0] term;
  } csp_cfg_t;

  localparam csp_cfg_t CFG_RST = '{SEL_9600, PAR_NONE, 1'b1, 1'b0, SYNC_NONE, 1'b0, 1'b0, 8'h00};
endpackage

// *** verilog/csp_serial_port.sv ***
// Purpose: Serial user port whose line settings come from a comma-separated configuration string.
// Assumes: All inputs but rst_n_i synchronous to sys_clk_i; register port with read data one cycle after the strobe.
// Notes: Single-character transmit and receive holding registers; sticky interrupt status cleared on read.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module csp_serial_port
  import csp_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic rx_i,
  input wire logic cts_i,
  output logic tx_o,
  output logic tx_en_o,
  output logic rts_o,
  output logic irq_o
);
  logic rst_meta, rst_n;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  function automatic logic [16:0] rate_div(input logic [2:0] sel);
    rate_div = 17'h00001;
    for (int i = 0; i < 8; i++) begin
      if (sel == 3'(i)) begin
        rate_div = 17'(CLK_HZ / RATES[i]);
      end
    end
  endfunction

  function automatic logic [11:0] mk_frame(input csp_cfg_t c, input logic [7:0] d);
    logic p;
    p = (^(c.data8 ? d : {1'b0, d[6:0]})) ^ (c.parity == PAR_ODD);
    if (c.parity == PAR_NONE) begin
      p = 1'b1;
    end
    mk_frame = c.data8 ? {2'h3, p, d, 1'b0} : {3'h7, p, d[6:0], 1'b0};
  endfunction

  csp_cfg_t cfg, w;
  logic [7:0] handle, err, tx_hold, rx_data, ch, ch_err, fin_err, rd_mux;
  logic [7:0] cfg_buf [BUF_DEPTH];
  logic [5:0] len, pidx;
  logic [2:0] field, sel_hit, sel_eff;
  logic [17:0] rate_val;
  logic [IRQ_W-1:0] istat, imask, ev;
  csp_pstate_t pst;
  logic ovf, done, fail, got_rate, stop_set, mode_seen, rate_hit, req;
  logic tx_full, tx_busy, held_off, paused, rx_full, rx_busy, rx_done, rx_stop_ok;
  logic send_mode, recv_mode, flow_req, data_ok, start, rx_store, line_err;
  logic [11:0] tx_frm;
  logic [3:0] tx_left, tx_nbits, rx_idx, rx_nb;
  logic [16:0] tx_cnt, rx_cnt, div;
  logic [8:0] rx_sh;
  logic [7:0] rx_got;

  assign req = wr_i && addr_i == A_CTRL && wdata_i[CTRL_REQ_BIT] && pst == PS_IDLE;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      handle <= 8'h00;
      len <= 6'h00;
      ovf <= 1'b0;
      imask <= '0;
    end else if (wr_i) begin
      case (addr_i)
        A_CTRL: begin
          if (wdata_i[CTRL_CLR_BIT]) begin
            len <= 6'h00;
            ovf <= 1'b0;
          end
        end
        A_HANDLE: handle <= wdata_i;
        A_CFGCH: begin
          if (len == 6'(BUF_DEPTH)) begin
            ovf <= 1'b1;
          end else begin
            len <= len + 6'h01;
          end
        end
        A_IMASK: imask <= wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // The string store has no reset; only the first len entries are ever read.
  always_ff @(posedge sys_clk_i) begin
    if (wr_i && addr_i == A_CFGCH && len != 6'(BUF_DEPTH)) begin
      cfg_buf[len[4:0]] <= wdata_i;
    end
  end

  assign ch = cfg_buf[pidx[4:0]];

  always_comb begin
    ch_err = ERR_NONE;
    if (!(field < 3'h5 && ch == CH_COMMA)) begin
      case (field)
        3'h0: if (ch < CH_0 || ch > CH_9) ch_err = ERR_RATE;
        3'h1: if (ch != CH_E && ch != CH_O && ch != CH_N) ch_err = ERR_PAR;
        3'h2: if (ch != CH_7 && ch != CH_8) ch_err = ERR_DATA;
        3'h3: if (ch != CH_1 && ch != CH_2) ch_err = ERR_STOP;
        3'h4: begin
          if (!mode_seen && ch != CH_N && ch != CH_S && ch != CH_R && ch != CH_B && ch != CH_H) begin
            ch_err = ERR_SYNC;
          end
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    rate_hit = 1'b0;
    sel_hit = SEL_9600;
    for (int i = 0; i < 8; i++) begin
      if (rate_val == 18'(RATES[i])) begin
        rate_hit = 1'b1;
        sel_hit = 3'(i);
      end
    end
    sel_eff = got_rate ? sel_hit : SEL_9600;
  end

  always_comb begin
    fin_err = err;
    if (fin_err == ERR_NONE && got_rate && !rate_hit) begin
      fin_err = ERR_RATE;
    end
    if (fin_err == ERR_NONE && sel_eff > SEL_9600 && w.sync != SYNC_HW) begin
      fin_err = ERR_FAST;
    end
  end

  // walk the fields in fixed order
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pst <= PS_IDLE;
      pidx <= 6'h00;
      field <= 3'h0;
      w <= CFG_RST;
      rate_val <= 18'h00000;
      got_rate <= 1'b0;
      stop_set <= 1'b0;
      mode_seen <= 1'b0;
      err <= ERR_NONE;
    end else begin
      case (pst)
        PS_IDLE: begin
          if (req) begin
            pst <= PS_SCAN;
            pidx <= 6'h00;
            field <= 3'h0;
            // every field starts at its default
            w <= CFG_RST;
            rate_val <= 18'h00000;
            got_rate <= 1'b0;
            stop_set <= 1'b0;
            mode_seen <= 1'b0;
            err <= (handle == 8'h00) ? ERR_HANDLE : (ovf ? ERR_LONG : ERR_NONE);
          end
        end
        PS_SCAN: begin
          if (pidx == len) begin
            pst <= PS_FIN;
          end else begin
            pidx <= pidx + 6'h01;
            if (err == ERR_NONE) begin
              err <= ch_err;
            end
            // a bare comma only moves on
            if (field < 3'h5 && ch == CH_COMMA) begin
              field <= field + 3'h1;
            end else begin
              case (field)
                3'h0: begin
                  got_rate <= 1'b1;
                  if (rate_val <= RATE_MAX) begin
                    rate_val <= 18'(rate_val * 18'd10) + {10'h000, ch - CH_0};
                  end
                end
                3'h1: w.parity <= (ch == CH_E) ? PAR_EVEN : ((ch == CH_O) ? PAR_ODD : PAR_NONE);
                3'h2: w.data8 <= (ch != CH_7);
                3'h3: begin
                  w.stop2 <= (ch == CH_2);
                  stop_set <= 1'b1;
                end
                3'h4: begin
                  if (!mode_seen) begin
                    mode_seen <= 1'b1;
                    case (ch)
                      CH_S: w.sync <= SYNC_SEND;
                      CH_R: w.sync <= SYNC_RECV;
                      CH_B: w.sync <= SYNC_BOTH;
                      CH_H: w.sync <= SYNC_HW;
                      default: w.sync <= SYNC_NONE;
                    endcase
                  end else begin
                    // character after the mode is the terminator
                    w.term_en <= 1'b1;
                    w.term <= ch;
                  end
                end
                default: begin
                  if (ch == CH_T && !w.txdis && !w.term_en) begin
                    w.txdis <= 1'b1;
                  end else begin
                    w.term_en <= 1'b1;
                    w.term <= ch;
                  end
                end
              endcase
            end
          end
        end
        PS_FIN: begin
          pst <= PS_IDLE;
          err <= fin_err;
        end
        default: pst <= PS_IDLE;
      endcase
    end
  end

  // A failed request leaves the previous line settings in force.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RST;
      done <= 1'b0;
      fail <= 1'b0;
    end else if (req) begin
      done <= 1'b0;
      fail <= 1'b0;
    end else if (pst == PS_FIN) begin
      // done and fail follow the code
      done <= (fin_err == ERR_NONE);
      fail <= (fin_err != ERR_NONE);
      if (fin_err == ERR_NONE) begin
        cfg <= w;
        cfg.rate_sel <= sel_eff;
        // default stop count depends on rate
        cfg.stop2 <= stop_set ? w.stop2 : (sel_eff == SEL_110);
      end
    end
  end

  assign div = rate_div(cfg.rate_sel);
  assign send_mode = cfg.sync == SYNC_SEND || cfg.sync == SYNC_BOTH;
  assign recv_mode = cfg.sync == SYNC_RECV || cfg.sync == SYNC_BOTH;
  // the flow character follows the receive holding state
  assign flow_req = send_mode && (rx_full != held_off);
  // data held while paused; data held while CTS is low in hardware handshake mode
  assign data_ok = tx_full && !(recv_mode && paused) && (cfg.sync != SYNC_HW || cts_i);
  assign start = !tx_busy && (flow_req || data_ok);
  assign tx_nbits = 4'h1 + (cfg.data8 ? 4'h8 : 4'h7) + {3'h0, cfg.parity != PAR_NONE} + (cfg.stop2 ? 4'h2 : 4'h1);

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_frm <= 12'hfff;
      tx_left <= 4'h0;
      tx_cnt <= 17'h00000;
      tx_o <= 1'b1;
      held_off <= 1'b0;
    end else begin
      if (!send_mode) begin
        held_off <= 1'b0;
      end else if (start && flow_req) begin
        held_off <= rx_full;
      end
      if (!tx_busy) begin
        if (start) begin
          // frame opens with a low start bit
          tx_frm <= mk_frame(cfg, flow_req ? (rx_full ? CH_XOFF : CH_XON) : tx_hold);
          tx_left <= tx_nbits - 4'h1;
          tx_cnt <= div - 17'h00001;
          tx_busy <= 1'b1;
          tx_o <= 1'b0;
        end
      end else if (tx_cnt != 17'h00000) begin
        tx_cnt <= tx_cnt - 17'h00001;
      end else if (tx_left == 4'h0) begin
        tx_busy <= 1'b0;
        tx_o <= 1'b1;
      end else begin
        tx_frm <= {1'b1, tx_frm[11:1]};
        tx_o <= tx_frm[1];
        tx_left <= tx_left - 4'h1;
        tx_cnt <= div - 17'h00001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_full <= 1'b0;
      tx_hold <= 8'h00;
      tx_en_o <= 1'b1;
      rts_o <= 1'b1;
    end else begin
      if (start && !flow_req) begin
        tx_full <= 1'b0;
      end else if (wr_i && addr_i == A_TXD && !tx_full) begin
        tx_full <= 1'b1;
        tx_hold <= wdata_i;
      end
      tx_en_o <= !cfg.txdis || tx_busy || start;
      // hold the partner off while full in hardware handshake mode
      rts_o <= !(cfg.sync == SYNC_HW && rx_full);
    end
  end

  assign rx_nb = (cfg.data8 ? 4'h8 : 4'h7) + {3'h0, cfg.parity != PAR_NONE};

  // Sampling happens at mid-bit, half a bit after the falling start edge.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy <= 1'b0;
      rx_cnt <= 17'h00000;
      rx_idx <= 4'h0;
      rx_sh <= 9'h000;
      rx_done <= 1'b0;
      rx_stop_ok <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!rx_i) begin
          rx_busy <= 1'b1;
          rx_cnt <= {1'b0, div[16:1]};
          rx_idx <= 4'h0;
        end
      end else if (rx_cnt != 17'h00000) begin
        rx_cnt <= rx_cnt - 17'h00001;
      end else begin
        rx_cnt <= div - 17'h00001;
        if (rx_idx == 4'h0) begin
          if (rx_i) begin
            rx_busy <= 1'b0;
          end else begin
            rx_idx <= 4'h1;
          end
        end else if (rx_idx <= rx_nb) begin
          rx_sh[rx_idx-4'h1] <= rx_i;
          rx_idx <= rx_idx + 4'h1;
        end else begin
          rx_busy <= 1'b0;
          rx_done <= 1'b1;
          rx_stop_ok <= rx_i;
        end
      end
    end
  end

  assign rx_got = cfg.data8 ? rx_sh[7:0] : {1'b0, rx_sh[6:0]};
  // parity is checked only when selected
  assign line_err = !rx_stop_ok || (cfg.parity != PAR_NONE &&
    ((cfg.data8 ? rx_sh[8] : rx_sh[7]) != ((^rx_got) ^ (cfg.parity == PAR_ODD))));
  assign rx_store = rx_done && !(recv_mode && (rx_got == CH_XON || rx_got == CH_XOFF));

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_full <= 1'b0;
      rx_data <= 8'h00;
      paused <= 1'b0;
    end else begin
      if (rx_store) begin
        rx_full <= 1'b1;
        rx_data <= rx_got;
      end else if (rd_i && addr_i == A_RXD) begin
        rx_full <= 1'b0;
      end
      if (!recv_mode) begin
        paused <= 1'b0;
      end else if (rx_done && rx_got == CH_XOFF) begin
        paused <= 1'b1;
      end else if (rx_done && rx_got == CH_XON) begin
        paused <= 1'b0;
      end
    end
  end

  assign ev = {rx_done && (line_err || (rx_store && rx_full)),
               rx_store && cfg.term_en && rx_got == cfg.term,
               start && !flow_req,
               rx_store,
               pst == PS_FIN};

  always_comb begin
    case (addr_i)
      A_STAT: rd_mux = {3'h0, rx_full, tx_full, pst != PS_IDLE, fail, done};
      A_HANDLE: rd_mux = handle;
      A_ERR: rd_mux = err;
      A_RXD: rd_mux = rx_data;
      A_ISTAT: rd_mux = {3'h0, istat};
      A_IMASK: rd_mux = {3'h0, imask};
      A_CFG: rd_mux = {cfg.txdis, cfg.sync, cfg.parity, cfg.data8, cfg.stop2};
      default: rd_mux = 8'h00;
    endcase
  end

  // A new event in the cycle of the clearing read survives it.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      istat <= '0;
      irq_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      istat <= ((rd_i && addr_i == A_ISTAT) ? '0 : istat) | ev;
      irq_o <= |(istat & imask);
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_tx_start;
    $rose(tx_busy);
  endsequence
  sequence s_seven_with(csp_par_t p);
    s_tx_start ##0 (cfg.parity == p && !cfg.data8);
  endsequence

  a_done_fail_excl: assert property ((done |-> err == ERR_NONE && !fail) and (fail |-> err != ERR_NONE))
    else $error("Done and fail disagree with the code.");
  a_fast_needs_hw: assert property (cfg.rate_sel > SEL_9600 |-> cfg.sync == SYNC_HW)
    else $error("Fast rate active without handshake.");
  a_start_bit_low: assert property (s_tx_start |-> !tx_o ##1 !tx_o)
    else $error("Start bit not low.");
  a_even_parity: assert property (s_seven_with(PAR_EVEN) |-> tx_frm[8] == ^tx_frm[7:1])
    else $error("Even parity bit wrong.");
  a_odd_parity: assert property (s_seven_with(PAR_ODD) |-> tx_frm[8] == ~^tx_frm[7:1])
    else $error("Odd parity bit wrong.");
  a_no_parity: assert property (s_seven_with(PAR_NONE) |-> tx_frm[8])
    else $error("Parity slot not idle high.");
  a_stop_count: assert property (s_tx_start |-> tx_left == tx_nbits - 4'h1 && tx_cnt == div - 17'h00001)
    else $error("Frame length wrong.");
  a_pause_hold: assert property (start && recv_mode && paused |-> flow_req)
    else $error("Data sent while paused.");
  a_flow_send: assert property (send_mode && rx_full && !held_off && !tx_busy |=> tx_busy)
    else $error("Flow character not started.");
  a_rts_hold: assert property (cfg.sync == SYNC_HW && rx_full |=> !rts_o)
    else $error("Request line not dropped.");
  a_drv_off: assert property (cfg.txdis && !tx_busy && !start |=> !tx_en_o)
    else $error("Driver left on while idle.");
endmodule

// *** bench/csp_far_end.sv ***
// Purpose: Remote serial device model on the line pins.
// Assumes: Fixed bit time in clock cycles; its own frames are 8N1.
// Notes: Its line idles high, as a pulled-up line would.
`timescale 1ns/1ps
module csp_far_end
  import csp_pkg::*;
#(
  parameter int BIT = 20
) (
  input wire logic sys_clk_i,
  input wire logic tx_i,
  output logic rx_o,
  output logic cts_o
);
  initial begin
    rx_o = 1'b1;
    cts_o = 1'b1;
  end
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk_i);
      rx_o <= f[i];
      repeat (BIT - 1) @(posedge sys_clk_i);
    end
  endtask
  // Samples n bits at mid-bit, the start bit first.
  task automatic catch_frame(input int n, output logic [15:0] v);
    int w;
    v = '0;
    w = 0;
    while (tx_i !== 1'b0 && w < 4000) begin
      @(posedge sys_clk_i);
      w++;
    end
    repeat (BIT / 2) @(posedge sys_clk_i);
    v[0] = tx_i;
    for (int i = 1; i < n; i++) begin
      repeat (BIT) @(posedge sys_clk_i);
      v[i] = tx_i;
    end
  endtask
endmodule

// *** bench/testbench.sv ***
// Purpose: Self-checking bench for the configurable serial port.
// Assumes: CLK_HZ shortened so 9600 baud is 20 cycles a bit.
// Notes: All line traffic runs at 9600 to keep the run short.
`timescale 1ns/1ps
module testbench;
  import csp_pkg::*;
  localparam int CLK = 192000;
  localparam int BIT = CLK / 9600;
  logic sys_clk_i, rst_n_i, wr_i, rd_i, rx_i, cts_i, tx_o, tx_en_o, rts_o, irq_o;
  logic [3:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic [15:0] v;
  logic [7:0] d;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  csp_serial_port #(.CLK_HZ(CLK)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i), .cts_i(cts_i),
    .tx_o(tx_o), .tx_en_o(tx_en_o), .rts_o(rts_o), .irq_o(irq_o));
  csp_far_end #(.BIT(BIT)) far (.sys_clk_i(sys_clk_i), .tx_i(tx_o), .rx_o(rx_i), .cts_o(cts_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic test_done();
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= x;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 x = rdata_o;
  endtask
  task automatic cfg(input logic [7:0] h, input string s, input logic [7:0] e, input logic [7:0] c);
    logic [7:0] x;
    int w;
    wr(A_CTRL, 8'h02);
    wr(A_HANDLE, h);
    for (int i = 0; i < s.len(); i++) begin
      wr(A_CFGCH, s[i]);
    end
    wr(A_CTRL, 8'h01);
    w = 0;
    x = 8'h00;
    while (x[1:0] == 2'b00 && w < 100) begin
      rd(A_STAT, x);
      w++;
    end
    chk("stat", x[1:0], (e == ERR_NONE) ? 2'b01 : 2'b10);
    rd(A_ERR, x);
    chk("err", x, e);
    rd(A_CFG, x);
    chk("cfg", x, c);
  endtask
  task automatic t_defaults();
    cfg(8'h05, "", ERR_NONE, 8'h02);
    wr(A_IMASK, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    chk("irq masked", irq_o, 1'b0);
    wr(A_IMASK, 8'h01);
    repeat (2) @(posedge sys_clk_i);
    chk("irq", irq_o, 1'b1);
    rd(A_ISTAT, d);
    chk("istat", d[0], 1'b1);
    repeat (2) @(posedge sys_clk_i);
    chk("irq clear", irq_o, 1'b0);
    rd(4'hf, d);
    chk("unmapped", d, 8'h00);
  endtask
  task automatic t_table();
    string s [12] = '{"110", "300", "600", "1200", "2400", "4800", "9600", "19200,,,,H",
      ",E", ",O", ",N,7", ",,,,B"};
    logic [7:0] e [12] = '{8'h03, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h42,
      8'h06, 8'h0a, 8'h00, 8'h32};
    for (int i = 0; i < 12; i++) begin
      cfg(8'h05, s[i], ERR_NONE, e[i]);
    end
    cfg(8'h00, "", ERR_HANDLE, 8'h32);
    cfg(8'h05, "19200", ERR_FAST, 8'h32);
  endtask
  task automatic t_tx(input string s, input logic [7:0] c, input logic [7:0] b, input int n,
    input logic [15:0] exp);
    cfg(8'h05, s, ERR_NONE, c);
    wr(A_TXD, b);
    far.catch_frame(n, v);
    chk("frame", v, exp);
  endtask
  task automatic t_txdis();
    cfg(8'h05, ",,,,N,T", ERR_NONE, 8'h82);
    chk("drv idle", tx_en_o, 1'b0);
    wr(A_TXD, 8'h3c);
    repeat (3) @(posedge sys_clk_i);
    chk("drv on", tx_en_o, 1'b1);
    far.catch_frame(10, v);
    chk("frame", v, {1'b1, 8'h3c, 1'b0});
    repeat (BIT) @(posedge sys_clk_i);
    chk("drv off", tx_en_o, 1'b0);
  endtask
  task automatic t_hw();
    cfg(8'h05, ",,,,H", ERR_NONE, 8'h42);
    chk("rts idle", rts_o, 1'b1);
    far.send_char(8'h33);
    repeat (2) @(posedge sys_clk_i);
    chk("rts held", rts_o, 1'b0);
    rd(A_RXD, d);
    chk("rxd hw", d, 8'h33);
    repeat (2) @(posedge sys_clk_i);
    chk("rts free", rts_o, 1'b1);
  endtask
  task automatic t_xoff();
    logic q;
    cfg(8'h05, ",,,,R", ERR_NONE, 8'h22);
    far.send_char(CH_XOFF);
    repeat (BIT) @(posedge sys_clk_i);
    wr(A_TXD, 8'h41);
    q = 1'b1;
    repeat (4 * BIT) begin
      @(posedge sys_clk_i);
      q = q & tx_o;
    end
    chk("held", q, 1'b1);
    fork
      far.send_char(CH_XON);
      far.catch_frame(10, v);
    join
    chk("resumed", v, {1'b1, 8'h41, 1'b0});
  endtask
  task automatic t_send();
    cfg(8'h05, ",,,,S", ERR_NONE, 8'h12);
    fork
      far.send_char(8'h5a);
      far.catch_frame(10, v);
    join
    chk("xoff", v, {1'b1, CH_XOFF, 1'b0});
    rd(A_RXD, d);
    chk("rxd", d, 8'h5a);
    far.catch_frame(10, v);
    chk("xon", v, {1'b1, CH_XON, 1'b0});
  endtask
  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    t_defaults();
    t_table();
    t_tx(",E,7", 8'h04, 8'h07, 10, {1'b1, 1'b1, 7'h07, 1'b0});
    t_tx(",O,7", 8'h08, 8'h07, 10, {1'b1, 1'b0, 7'h07, 1'b0});
    t_tx("", 8'h02, 8'ha5, 10, {1'b1, 8'ha5, 1'b0});
    t_tx(",N,7", 8'h00, 8'h07, 9, {1'b1, 7'h07, 1'b0});
    t_hw();
    t_txdis();
    t_xoff();
    t_send();
    test_done();
  end
endmodule
